// [verilog/cciu_pkg.sv]
// shared constants, types and decode function of the combined custom instruction unit
package cciu_pkg;

  localparam int DATA_W  = 32;
  localparam int SEL_W   = 8;
  localparam int NUM_FN  = 4;
  localparam int NUM_FIX = 3;

  // selector codes carried with each instruction
  localparam logic [7:0] SEL_ADD = 8'h00;
  localparam logic [7:0] SEL_MUL = 8'h01;
  localparam logic [7:0] SEL_ROT = 8'h02;
  localparam logic [7:0] SEL_POP = 8'h03;

  // cycle counts of the fixed latency functions, indexed like the selector codes
  localparam int LAT_ADD = 1;
  localparam int LAT_MUL = 3;
  localparam int LAT_ROT = 2;

  // register byte offsets on the apb side
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_COUNT  = 12'h008;
  localparam logic [11:0] REG_ID     = 12'h00C;

  // reset values and field positions
  localparam logic [3:0]  CTRL_RST       = 4'hF;
  localparam int          ST_BUSY_BIT    = 0;
  localparam int          ST_UNASG_BIT   = 1;
  localparam int          ST_SEL_LSB     = 8;
  localparam logic [31:0] ID_VALUE       = 32'h0C1A_0001; // arbitrary value

  // request from the processor and answer back to it
  typedef struct packed {
    logic              start;
    logic [SEL_W-1:0]  sel;
    logic [DATA_W-1:0] dataa;
    logic [DATA_W-1:0] datab;
  } cciu_req_t;

  typedef struct packed {
    logic              done;
    logic [DATA_W-1:0] result;
  } cciu_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } cciu_state_t;

  // one-hot decode of a selector value; all zero for an unassigned code
  function automatic logic [NUM_FN-1:0] cciu_sel_dec(input logic [SEL_W-1:0] sel);
    logic [NUM_FN-1:0] hot;
    hot = 4'h0;
    if (sel < 8'(NUM_FN)) begin
      hot[sel[1:0]] = 1'b1;
    end
    return hot;
  endfunction

endpackage

// [verilog/cciu_delay_chain.sv]
// shift chain that delays a start pulse by a fixed number of cycles
`timescale 1ns/1ps
module cciu_delay_chain #(
  parameter int DEPTH = 1
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic pulse_in,
  output logic      pulse_out
);

  logic [DEPTH-1:0] chain_r;

  // refuse a chain that cannot hold a pulse
  if (DEPTH < 1) begin : g_bad_depth
    $error("cciu_delay_chain: DEPTH must be at least 1");
  end

  // shift the pulse one stage per clock; a single stage has no lower slice to shift
  if (DEPTH == 1) begin : g_single
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        chain_r <= '0;
      end else begin
        chain_r[0] <= pulse_in;
      end
    end
  end else if (DEPTH > 1) begin : g_multi
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        chain_r <= '0;
      end else begin
        chain_r <= {chain_r[DEPTH-2:0], pulse_in};
      end
    end
  end

  assign pulse_out = chain_r[DEPTH-1];

endmodule // cciu_delay_chain

// [verilog/cciu_top.sv]
// combined custom instruction unit: merged functions, done sequencing, apb registers
//
// Contract
// - each instruction brings at most two operands and yields exactly one result.
// - clock, reset, selector and status signals support the multicycle functions.
// - the result feeds the processor's alu output multiplexer as a 32-bit word.
// - selector bits choose the function and an internal multiplexer drives the result.
// - the internal output multiplexer is registered to keep it off the critical path.
// - every merged function shows the same done handshake to the processor.
// - each function is either fixed latency or signals completion with its own done bit.
// - a fixed latency function gets its done bit from a start delay chain of its cycle count.
// - the single done output is the or of all function done bits; the unit also raises it for an unassigned or disabled selector.
// - the unit attaches to the alu through one slave port taking operands, giving a result.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module cciu_top #(
  parameter int          DATA_W = cciu_pkg::DATA_W,
  parameter logic [31:0] ID_VAL = cciu_pkg::ID_VALUE // arbitrary value
) (
  input  wire logic                sys_clk_in,
  input  wire logic                rst_in,
  input  wire cciu_pkg::cciu_req_t ci_req_in,
  output cciu_pkg::cciu_rsp_t      ci_rsp_out,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [11:0]         paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic [31:0]              prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out
);

  // the datapath is fixed to the packed request width
  if (DATA_W != cciu_pkg::DATA_W) begin : g_bad_width
    $error("cciu_top: DATA_W must equal the package data width");
  end

  localparam int NFN = cciu_pkg::NUM_FN;
  localparam int LAT [cciu_pkg::NUM_FIX] = '{cciu_pkg::LAT_ADD, cciu_pkg::LAT_MUL,
                                             cciu_pkg::LAT_ROT};

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [3:0]            fn_en_r;
  logic [DATA_W-1:0]     op_a_r;
  logic [DATA_W-1:0]     op_b_r;
  logic [NFN-1:0]        fn_hot;
  logic                  start_ok;
  logic                  start_bad;
  logic [NFN-1:0]        fn_done;
  logic [DATA_W-1:0]     fn_res [NFN];
  logic [DATA_W-1:0]     res_mux;
  logic                  done_any;
  logic [63:0]           rot_wide;
  logic [DATA_W-1:0]     pop_work_r;
  logic [5:0]            pop_cnt_r;
  logic                  pop_busy_r;
  logic                  pop_done_r;
  cciu_pkg::cciu_state_t state_r;
  cciu_pkg::cciu_state_t state_nxt;
  cciu_pkg::cciu_rsp_t   rsp_r;
  logic [7:0]            last_sel_r;
  logic                  last_unasg_r;
  logic [15:0]           done_cnt_r;
  logic [15:0]           unasg_cnt_r;
  logic [31:0]           prdata_r;
  logic                  pready_r;
  logic                  pslverr_r;
  logic                  apb_setup;
  logic                  apb_write;
  logic                  addr_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // instruction acceptance and operand capture

  // decode the selector against the enabled functions
  assign fn_hot    = cciu_pkg::cciu_sel_dec(ci_req_in.sel) & fn_en_r;
  assign start_ok  = ci_req_in.start && (fn_hot != '0);
  assign start_bad = ci_req_in.start && (fn_hot == '0);

  // latch both operands on the start pulse; they stay while the processor stalls
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      op_a_r <= '0;
      op_b_r <= '0;
    end else if (ci_req_in.start) begin
      op_a_r <= ci_req_in.dataa;
      op_b_r <= ci_req_in.datab;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // function datapaths

  // rotate left by the low five bits of the second operand
  assign rot_wide = {op_a_r, op_a_r} << op_b_r[4:0];

  // results computed from the latched operands
  always_comb begin
    fn_res[0] = op_a_r + op_b_r;
    fn_res[1] = DATA_W'(op_a_r * op_b_r);
    fn_res[2] = rot_wide[63:32];
    fn_res[3] = {26'h0, pop_cnt_r};
  end

  // fixed latency functions: done bit from a delayed start pulse
  for (genvar i = 0; i < cciu_pkg::NUM_FIX; i++) begin : g_fix
    cciu_delay_chain #(
      .DEPTH (LAT[i])
    ) u_chain (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .pulse_in   (ci_req_in.start && fn_hot[i]),
      .pulse_out  (fn_done[i])
    );
  end

  // variable latency population count: one set bit cleared per cycle
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pop_work_r <= '0;
      pop_cnt_r  <= 6'h00;
      pop_busy_r <= 1'b0;
      pop_done_r <= 1'b0;
    end else if (ci_req_in.start && fn_hot[3]) begin
      pop_work_r <= ci_req_in.dataa;
      pop_cnt_r  <= 6'h00;
      pop_busy_r <= 1'b1;
      pop_done_r <= 1'b0;
    end else if (pop_busy_r) begin
      if (pop_work_r == '0) begin
        pop_busy_r <= 1'b0;
        pop_done_r <= 1'b1;
      end else begin
        pop_work_r <= pop_work_r & (pop_work_r - DATA_W'(1));
        pop_cnt_r  <= pop_cnt_r + 6'h01;
      end
    end else begin
      pop_done_r <= 1'b0;
    end
  end

  assign fn_done[3] = pop_done_r;

  ////////////////////////////////////////////////////////////////////////////////
  // done combining and output multiplexer

  // single done is the or of all function done bits
  assign done_any = |fn_done;

  // select the finishing function's result; only one function runs at a time
  always_comb begin
    res_mux = '0;
    for (int k = 0; k < NFN; k++) begin
      if (fn_done[k]) begin
        res_mux = fn_res[k];
      end
    end
  end

  // registered output stage: done and result leave the unit together
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rsp_r <= '0;
    end else if (start_bad) begin
      rsp_r.done   <= 1'b1;
      rsp_r.result <= '0;
    end else if (done_any) begin
      rsp_r.done   <= 1'b1;
      rsp_r.result <= res_mux;
    end else begin
      rsp_r.done   <= 1'b0;
    end
  end

  assign ci_rsp_out = rsp_r;

  ////////////////////////////////////////////////////////////////////////////////
  // run state and status

  // busy from accepted start until the combined done
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      cciu_pkg::ST_IDLE: begin
        if (start_ok) begin
          state_nxt = cciu_pkg::ST_RUN;
        end
      end
      cciu_pkg::ST_RUN: begin
        if (done_any) begin
          state_nxt = cciu_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = cciu_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_r <= cciu_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // last selector and unassigned flag, captured per instruction
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      last_sel_r   <= 8'h00;
      last_unasg_r <= 1'b0;
    end else if (ci_req_in.start) begin
      last_sel_r   <= ci_req_in.sel;
      last_unasg_r <= start_bad;
    end
  end

  // completion counters; a write to the count register clears each counter that does not count in that cycle
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      done_cnt_r  <= 16'h0000;
      unasg_cnt_r <= 16'h0000;
    end else begin
      if (done_any) begin
        done_cnt_r <= done_cnt_r + 16'h0001;
      end else if (apb_write && paddr_in == cciu_pkg::REG_COUNT) begin
        done_cnt_r <= 16'h0000;
      end
      if (start_bad) begin
        unasg_cnt_r <= unasg_cnt_r + 16'h0001;
      end else if (apb_write && paddr_in == cciu_pkg::REG_COUNT) begin
        unasg_cnt_r <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait-free access phase, all answers registered

  assign apb_setup = psel_in && !penable_in;
  assign apb_write = psel_in && penable_in && pready_r && pwrite_in && !pslverr_r;
  assign addr_hit  = (paddr_in == cciu_pkg::REG_CTRL)  || (paddr_in == cciu_pkg::REG_STATUS) ||
                     (paddr_in == cciu_pkg::REG_COUNT) || (paddr_in == cciu_pkg::REG_ID);

  // prepare ready, error and read data during the setup cycle
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (apb_setup) begin
      pready_r  <= 1'b1;
      pslverr_r <= !addr_hit;
      prdata_r  <= 32'h0000_0000;
      if (!pwrite_in) begin
        unique case (paddr_in)
          cciu_pkg::REG_CTRL: begin
            prdata_r <= {28'h0, fn_en_r};
          end
          cciu_pkg::REG_STATUS: begin
            prdata_r[cciu_pkg::ST_BUSY_BIT]                   <= (state_r == cciu_pkg::ST_RUN);
            prdata_r[cciu_pkg::ST_UNASG_BIT]                  <= last_unasg_r;
            prdata_r[cciu_pkg::ST_SEL_LSB +: 8]               <= last_sel_r;
          end
          cciu_pkg::REG_COUNT: begin
            prdata_r <= {unasg_cnt_r, done_cnt_r};
          end
          cciu_pkg::REG_ID: begin
            prdata_r <= ID_VAL;
          end
          default: begin
            prdata_r <= 32'h0000_0000;
          end
        endcase
      end
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // function enable mask; a disabled function answers as unassigned
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      fn_en_r <= cciu_pkg::CTRL_RST;
    end else if (apb_write && paddr_in == cciu_pkg::REG_CTRL) begin
      fn_en_r <= pwdata_in[3:0];
    end
  end

  assign prdata_out  = prdata_r;
  assign pready_out  = pready_r;
  assign pslverr_out = pslverr_r;

endmodule // cciu_top

// [testbench/cciu_sva.sv]
// assertions on the instruction and apb ports of the unit
`timescale 1ns/1ps
module cciu_sva #(
  parameter logic [31:0] ID_VAL = 32'h0000_0000
) (
  input wire logic                sys_clk_in,
  input wire logic                rst_in,
  input wire cciu_pkg::cciu_req_t ci_req_in,
  input wire cciu_pkg::cciu_rsp_t ci_rsp_out,
  input wire logic                psel_in,
  input wire logic                penable_in,
  input wire logic                pwrite_in,
  input wire logic [11:0]         paddr_in,
  input wire logic [31:0]         pwdata_in,
  input wire logic [31:0]         prdata_out,
  input wire logic                pready_out,
  input wire logic                pslverr_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // short names for the instruction handshake
  wire logic       go = ci_req_in.start;
  wire logic       dn = ci_rsp_out.done;
  wire logic [7:0] sl = ci_req_in.sel;

  done_pulse_a: assert property (dn |=> !dn)
    else $error("done longer than one cycle");
  unasg_zero_a: assert property (go && sl > 8'h03 |=> dn && ci_rsp_out.result == 32'h0)
    else $error("unassigned selector not answered with zero");
  add_lat_a: assert property (go && sl == 8'h00 |=> dn or (!dn ##1 dn))
    else $error("add done at wrong cycle");
  rot_lat_a: assert property (go && sl == 8'h02 |=> dn or (!dn [*2] ##1 dn))
    else $error("rotate done at wrong cycle");
  mul_lat_a: assert property (go && sl == 8'h01 |=> dn or (!dn [*3] ##1 dn))
    else $error("multiply done at wrong cycle");
  done_bound_a: assert property (go |-> ##[1:40] dn)
    else $error("no done after start");
  result_hold_a: assert property (!dn && !$past(rst_in) |-> $stable(ci_rsp_out.result))
    else $error("result moved without done");
  apb_ready_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  err_zero_a: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("error without ready or with data");
  id_read_a: assert property (pready_out && !pwrite_in && paddr_in == 12'h00C
    |-> prdata_out == ID_VAL)
    else $error("identity read wrong");
  cover property (go && sl > 8'h03);
  cover property (go && sl == 8'h01 ##4 dn);
  cover property (pslverr_out);
endmodule // cciu_sva

// [testbench/cciu_ci_master.sv]
// instruction master model: issues one instruction and stalls until done
`timescale 1ns/1ps
module cciu_ci_master (
  input  wire logic                sys_clk_in,
  output cciu_pkg::cciu_req_t      req_out,
  input  wire cciu_pkg::cciu_rsp_t rsp_in
);
  initial req_out = '0;
  // called just after a rising edge; lat counts cycles from start to done
  task automatic issue(input logic [7:0] sel, input logic [31:0] a, input logic [31:0] b,
                       output logic [31:0] res, output int lat);
    int n;
    n = 0;
    req_out <= '{1'b1, sel, a, b};
    @(posedge sys_clk_in);
    req_out <= '{1'b0, ~sel, ~a, ~b}; // operands are not held once taken
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (rsp_in.done !== 1'b1 && n < 60);
    res = rsp_in.result;
    lat = n;
  endtask
endmodule // cciu_ci_master

// [testbench/tb_top.sv]
// self-checking bench of the combined custom instruction unit
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] ID_T = 32'h5A5A_0F0F; // arbitrary value
  logic                sys_clk_in;
  logic                rst_in;
  logic                psel, penable, pwrite, pready, pslverr;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd, res, r;
  cciu_pkg::cciu_req_t req;
  cciu_pkg::cciu_rsp_t rsp;
  int                  n_errors = 0, n_checks = 0, cyc = 0, lat;

  cciu_top #(.ID_VAL(ID_T)) i_cciu_top (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .ci_req_in(req), .ci_rsp_out(rsp), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr));
  cciu_ci_master i_cciu_ci_master (.sys_clk_in(sys_clk_in), .req_out(req), .rsp_in(rsp));

  // 50 ns clock
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one apb transfer, released after pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do @(posedge sys_clk_in); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd;
    @(posedge sys_clk_in);
  endtask

  // expected result and done cycle of one instruction
  function automatic logic [31:0] fres(input logic [7:0] s, input logic [31:0] a, b);
    case (s)
      8'h00: return a + b;
      8'h01: return a * b;
      8'h02: return (a << b[4:0]) | (a >> (6'd32 - {1'b0, b[4:0]}));
      8'h03: return $countones(a);
      default: return 32'h0;
    endcase
  endfunction
  function automatic int flat(input logic [7:0] s, input logic [31:0] a);
    case (s)
      8'h00: return cciu_pkg::LAT_ADD + 1;
      8'h01: return cciu_pkg::LAT_MUL + 1;
      8'h02: return cciu_pkg::LAT_ROT + 1;
      8'h03: return $countones(a) + 3;
      default: return 1;
    endcase
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic run(input logic [7:0] s, input logic [31:0] a, b, input logic en);
    i_cciu_ci_master.issue(s, a, b, res, lat);
    chk("result", res, en ? fres(s, a, b) : 32'h0);
    chk("latency", 32'(lat), en ? 32'(flat(s, a)) : 32'h1);
  endtask

  // watchdog on a cycle ceiling
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  // main sequence
  initial begin
    logic e;
    rst_in = 1'b1;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0;
    r = 32'hC12B216F;
    repeat (6) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    chk("done in reset", {31'h0, rsp.done}, 32'h0);
    apb(1'b0, cciu_pkg::REG_CTRL, 32'h0, rd, e);
    chk("ctrl reset", rd, 32'h0000000F);
    apb(1'b1, cciu_pkg::REG_ID, 32'hFFFFFFFF, rd, e);
    apb(1'b0, cciu_pkg::REG_ID, 32'h0, rd, e);
    chk("id", rd, ID_T);
    apb(1'b0, 12'h010, 32'h0, rd, e);
    chk("unmapped", {31'h0, e}, 32'h1);
    apb(1'b1, cciu_pkg::REG_COUNT, 32'h0, rd, e);
    run(8'h03, 32'h0, 32'h0, 1'b1);
    run(8'h03, 32'hFFFFFFFF, 32'h0, 1'b1);
    run(8'h02, 32'h80000001, 32'h1F, 1'b1);
    run(8'h01, 32'hFFFFFFFF, 32'hFFFFFFFF, 1'b1);
    run(8'hFF, 32'h1, 32'h1, 1'b1);
    apb(1'b0, cciu_pkg::REG_STATUS, 32'h0, rd, e);
    chk("status", rd & 32'h0000FF03, 32'h0000FF02);
    apb(1'b0, cciu_pkg::REG_COUNT, 32'h0, rd, e);
    chk("unassigned count", {16'h0, rd[31:16]}, 32'h1);
    chk("done count", {16'h0, rd[15:0]}, 32'h4);
    apb(1'b1, cciu_pkg::REG_CTRL, 32'h0000000E, rd, e);
    run(8'h00, 32'h5, 32'h7, 1'b0);
    apb(1'b1, cciu_pkg::REG_CTRL, 32'h0000000F, rd, e);
    run(8'h00, 32'hFFFFFFFF, 32'h1, 1'b1);
    for (int i = 0; i < 40; i++) begin
      r = lfsr(r);
      rd = r;
      r = lfsr(r);
      run(r[2:0] < 3'd5 ? {6'h00, r[4:3]} : r[15:8] | 8'h04, rd, r, 1'b1);
    end
    close_out();
  end
endmodule // tb_top

bind cciu_top cciu_sva #(.ID_VAL(ID_VAL)) i_cciu_sva (.sys_clk_in(sys_clk_in),
  .rst_in(rst_in), .ci_req_in(ci_req_in), .ci_rsp_out(ci_rsp_out), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out));
